// >>> core/tx_audio_consts.svh
`ifndef TX_AUDIO_CONSTS_SVH
`define TX_AUDIO_CONSTS_SVH

// ==========================================
// Peak input range per attenuation code, mV
`define RANGE_MV_CODE0 10'h0BE
`define RANGE_MV_CODE1 10'h12D
`define RANGE_MV_CODE2 10'h1A0
`define RANGE_MV_CODE3 10'h27C

// ==========================================
// Fixed-point layout
`define SCALE_FRAC_BITS 16
`define DIV_W 26
`define DIV_CNT_W 5
`define GAIN_FRAC_BITS 4
`define GAIN_W 11
`define DB_PER_OCTAVE_Q 11'h060
`define INV_OCTAVE_MUL 17'h002AB
`define MANT_ONE 10'h100
`define MANT_LIN_MUL 9'h1C0
`define MANT_SQ_MUL 10'h271
`define DEV_SHIFT 15
`define SILENT_DBFS 8'h80

// ==========================================
// Reset values
`define GAIN_RESET 11'h000
`define SAMPLE_RESET 16'h0000
`define DEV_RESET 17'h00000

`endif

// >>> core/tx_audio_pkg.sv
package tx_audio_pkg;

	// ==========================================
	// Stereo input sample with its strobe
	typedef struct packed {
		logic valid;
		logic signed [15:0] left;
		logic signed [15:0] right;
	} audio_pair_type;

	// ==========================================
	// Stereo deviation sample, 10 Hz units
	typedef struct packed {
		logic valid;
		logic signed [16:0] left;
		logic signed [16:0] right;
	} dev_pair_type;

	// ==========================================
	// Compressor settings
	typedef struct packed {
		logic enable;
		logic [5:0] gainDb;
		logic signed [7:0] thresholdDbfs;
		logic [7:0] attackStep;
		logic [7:0] releaseStep;
	} drc_cfg_type;

	// ==========================================
	// Per-sample sequencing states
	typedef enum logic [5:0] {
		S_IDLE = 6'b000001,
		S_DIVK = 6'b000010,
		S_NORM = 6'b000100,
		S_DIVG = 6'b001000,
		S_SMOOTH = 6'b010000,
		S_OUT = 6'b100000
	} step_type;

endpackage : tx_audio_pkg

// >>> core/tx_audio_level_conditioning.sv
`timescale 1ns/1ps
`default_nettype none
`include "tx_audio_consts.svh"

module tx_audio_level_conditioning
	import tx_audio_pkg::*;
#(
	parameter int HOLD_W = 16 // Width of the hold-time counters
) (
	input wire logic clk, // 250 MHz clock
	input wire logic rst_n, // Async reset, active low
	input wire audio_pair_type lineSample, // Line input sample and strobe
	input wire logic [1:0] lineAttenCode, // Input range code
	input wire logic [9:0] linePeakLevelMv, // Expected peak at pins, mV
	input wire logic [15:0] audioDeviation, // Max audio deviation, 10 Hz units
	input wire logic signed [7:0] quietThresholdDbfs, // Quiet threshold
	input wire logic signed [7:0] loudThresholdDbfs, // Loud threshold
	input wire logic [HOLD_W-1:0] quietHoldTime, // Quiet hold, samples
	input wire logic [HOLD_W-1:0] loudHoldTime, // Loud hold, samples
	input wire drc_cfg_type drcCfg, // Compressor settings
	output dev_pair_type devSample, // Conditioned deviation sample
	output logic quietFlag, // Audio quiet long enough
	output logic loudFlag // Audio loud long enough
);

	// ==========================================
	// Elaboration check
	if (HOLD_W < 1 || HOLD_W > 32) begin : holdWidthCheck
		$error("HOLD_W must be 1 to 32");
	end

	// ==========================================
	// Helper functions

	// Clamp a wide signed value to 16 bits
	function automatic logic signed [15:0] sat16(input logic signed [47:0] v);
		if (v > 48'sh7FFF) begin
			return 16'sh7FFF;
		end else if (v < -48'sh8000) begin
			return -16'sh8000;
		end
		return v[15:0];
	endfunction : sat16

	// Magnitude, clamped to 15 bits
	function automatic logic [14:0] mag15(input logic signed [15:0] v);
		logic [15:0] a;
		a = v[15] ? 16'(-v) : 16'(v);
		return a[15] ? 15'h7FFF : a[14:0];
	endfunction : mag15

	// Approximate level in dBFS: 6 dB per octave plus mantissa
	function automatic logic signed [7:0] dbfsOf(input logic [14:0] m);
		logic signed [7:0] lvl;
		logic [2:0] frac;
		lvl = `SILENT_DBFS;
		frac = 3'h0;
		for (int p = 0; p < 15; p++) begin
			if (m[p]) begin
				frac = 3'((18'(m) << 3) >> p);
				lvl = 8'(6 * (p - 15) + ((6 * int'(frac)) >> 3));
			end
		end
		return lvl;
	endfunction : dbfsOf

	// Multiply by a gain given in dB (Q4): octave shift and quadratic mantissa
	// A straight-line mantissa overshoots by up to 6 percent mid-octave
	function automatic logic signed [15:0] applyGain(input logic signed [15:0] x,
			input logic [`GAIN_W-1:0] g);
		logic [27:0] oct;
		logic [3:0] shift;
		logic [10:0] rem;
		logic [9:0] mant;
		logic signed [47:0] prod;
		oct = 28'(g) * 28'(`INV_OCTAVE_MUL);
		shift = 4'(oct >> 16);
		rem = g - 11'(shift * `DB_PER_OCTAVE_Q);
		mant = `MANT_ONE + 10'((19'(rem) * 19'(`MANT_LIN_MUL)) >> 8)
			+ 10'((26'(rem) * 26'(rem) * 26'(`MANT_SQ_MUL)) >> 16);
		prod = 48'(x) * $signed({38'h0, mant});
		prod = (prod <<< shift) >>> 8;
		return sat16(prod);
	endfunction : applyGain

	// Instantaneous deviation in 10 Hz units
	function automatic logic signed [16:0] toDev(input logic signed [15:0] x,
			input logic [15:0] dev);
		logic signed [33:0] p;
		p = 34'(x) * $signed({18'h0, dev});
		return 17'(p >>> `DEV_SHIFT);
	endfunction : toDev

	// ==========================================
	// State
	step_type step_q; // Per-sample sequencer
	logic signed [15:0] rawL_q, rawR_q; // Captured input
	logic signed [15:0] normL_q, normR_q; // Scaled to deviation full scale
	logic signed [7:0] level_q; // Sample level, dBFS
	logic [`DIV_W-1:0] scaleK_q; // Range/peak ratio, Q16
	logic [`DIV_W:0] rem_q; // Divider remainder
	logic [`DIV_W-1:0] quo_q; // Divider numerator/quotient
	logic [`DIV_W-1:0] den_q; // Divider denominator
	logic [`DIV_CNT_W-1:0] divCnt_q; // Divider bits left
	logic [`GAIN_W-1:0] gain_q; // Current compressor gain, dB Q4
	logic [HOLD_W-1:0] quietCnt_q, loudCnt_q; // Hold counters
	dev_pair_type devSample_q; // Output sample
	logic quietFlag_q, loudFlag_q; // Output indicators

	// ==========================================
	// Decoding and selection
	logic [9:0] rangeMv; // Range for selected code
	assign rangeMv = (lineAttenCode == 2'h0) ? `RANGE_MV_CODE0 :
		(lineAttenCode == 2'h1) ? `RANGE_MV_CODE1 :
		(lineAttenCode == 2'h2) ? `RANGE_MV_CODE2 : `RANGE_MV_CODE3;

	// Zero peak level would divide by zero; treat as 1 mV
	logic [9:0] peakSafe;
	assign peakSafe = (linePeakLevelMv == 10'h000) ? 10'h001 : linePeakLevelMv;

	// Restoring divider step
	logic [`DIV_W:0] trial; // Shifted remainder
	logic [`DIV_W:0] diff; // Remainder minus denominator
	logic divFits; // Subtraction succeeds
	assign trial = {rem_q[`DIV_W-1:0], quo_q[`DIV_W-1]};
	assign diff = trial - {1'b0, den_q};
	assign divFits = !diff[`DIV_W];

	// Normalised samples: input times range/peak
	logic signed [47:0] scaledL, scaledR;
	assign scaledL = (48'(rawL_q) * $signed({22'h0, scaleK_q})) >>> `SCALE_FRAC_BITS;
	assign scaledR = (48'(rawR_q) * $signed({22'h0, scaleK_q})) >>> `SCALE_FRAC_BITS;

	// Stereo-linked level of the new sample
	logic [14:0] magL, magR;
	logic signed [7:0] levelNow;
	assign magL = mag15(sat16(scaledL));
	assign magR = mag15(sat16(scaledR));
	assign levelNow = dbfsOf((magL > magR) ? magL : magR);

	// Compressor threshold as a positive divisor
	logic signed [7:0] thr;
	logic [7:0] thrMag;
	assign thr = drcCfg.thresholdDbfs;
	assign thrMag = (thr < 0) ? 8'(-thr) : 8'h01;

	// Level clamped to [threshold, 0] for the compression curve
	logic [7:0] lvlMag;
	assign lvlMag = (levelNow >= 0) ? 8'h00 : (levelNow < thr) ? thrMag : 8'(-levelNow);

	// Gain in Q4 dB above threshold is G * L / T; reaches 0 at full scale
	logic [`GAIN_W-1:0] gainFull;
	assign gainFull = {1'b0, drcCfg.gainDb, 4'h0};
	logic [`DIV_W-1:0] gainNum;
	assign gainNum = `DIV_W'(gainFull) * `DIV_W'(lvlMag);

	// Target gain for this sample
	logic [`GAIN_W-1:0] target;
	assign target = !drcCfg.enable ? `GAIN_RESET :
		(level_q < thr) ? gainFull :
		(quo_q > `DIV_W'(gainFull)) ? gainFull :
		`GAIN_W'(quo_q);

	// Gain ramp toward target by attack or release step
	logic [`GAIN_W-1:0] gainDown, gainUp, gainNext;
	assign gainDown = (gain_q - target > `GAIN_W'(drcCfg.attackStep)) ?
		gain_q - `GAIN_W'(drcCfg.attackStep) : target;
	assign gainUp = (target - gain_q > `GAIN_W'(drcCfg.releaseStep)) ?
		gain_q + `GAIN_W'(drcCfg.releaseStep) : target;
	assign gainNext = !drcCfg.enable ? `GAIN_RESET :
		(target < gain_q) ? gainDown : gainUp;

	// Hold counters: qualified quiet and loud detection
	logic isQuiet, isLoud;
	assign isQuiet = levelNow < quietThresholdDbfs;
	assign isLoud = levelNow > loudThresholdDbfs;
	logic [HOLD_W-1:0] quietCntNext, loudCntNext;
	assign quietCntNext = !isQuiet ? '0 :
		(quietCnt_q == quietHoldTime) ? quietCnt_q : quietCnt_q + 1'b1;
	assign loudCntNext = !isLoud ? '0 :
		(loudCnt_q == loudHoldTime) ? loudCnt_q : loudCnt_q + 1'b1;

	// Compressed samples, then mapped to deviation
	logic signed [15:0] drcL, drcR;
	assign drcL = applyGain(normL_q, gain_q);
	assign drcR = applyGain(normR_q, gain_q);

	// ==========================================
	// Sequencer: one pass per audio sample
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			step_q <= S_IDLE;
		end else begin
			unique case (step_q)
				S_IDLE: if (lineSample.valid) step_q <= S_DIVK;
				S_DIVK: if (divCnt_q == '0) step_q <= S_NORM;
				S_NORM: step_q <= S_DIVG;
				S_DIVG: if (divCnt_q == '0) step_q <= S_SMOOTH;
				S_SMOOTH: step_q <= S_OUT;
				S_OUT: step_q <= S_IDLE;
			endcase
		end
	end

	// ==========================================
	// Sample capture
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rawL_q <= `SAMPLE_RESET;
			rawR_q <= `SAMPLE_RESET;
		end else if (step_q == S_IDLE && lineSample.valid) begin
			rawL_q <= lineSample.left;
			rawR_q <= lineSample.right;
		end
	end

	// ==========================================
	// Shared divider: range/peak, then compressor gain
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rem_q <= '0;
			quo_q <= '0;
			den_q <= '0;
			divCnt_q <= '0;
		end else if (step_q == S_IDLE) begin
			rem_q <= '0;
			quo_q <= {rangeMv, 16'h0000};
			den_q <= `DIV_W'(peakSafe);
			divCnt_q <= `DIV_CNT_W'(`DIV_W);
		end else if (step_q == S_NORM) begin
			rem_q <= '0;
			quo_q <= gainNum;
			den_q <= `DIV_W'(thrMag);
			divCnt_q <= `DIV_CNT_W'(`DIV_W);
		end else if (divCnt_q != '0) begin
			rem_q <= divFits ? diff : trial;
			quo_q <= {quo_q[`DIV_W-2:0], divFits};
			divCnt_q <= divCnt_q - 1'b1;
		end
	end

	// ==========================================
	// Scale factor, normalised samples, level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scaleK_q <= '0;
			normL_q <= `SAMPLE_RESET;
			normR_q <= `SAMPLE_RESET;
			level_q <= `SILENT_DBFS;
		end else if (step_q == S_DIVK && divCnt_q == '0) begin
			scaleK_q <= quo_q;
		end else if (step_q == S_NORM) begin
			normL_q <= sat16(scaledL);
			normR_q <= sat16(scaledR);
			level_q <= levelNow;
		end
	end

	// ==========================================
	// Quiet and loud indicators
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			quietCnt_q <= '0;
			loudCnt_q <= '0;
			quietFlag_q <= 1'b0;
			loudFlag_q <= 1'b0;
		end else if (step_q == S_NORM) begin
			quietCnt_q <= quietCntNext;
			loudCnt_q <= loudCntNext;
			quietFlag_q <= isQuiet && (quietCntNext == quietHoldTime);
			loudFlag_q <= isLoud && (loudCntNext == loudHoldTime);
		end
	end

	// ==========================================
	// Compressor gain ramp
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			gain_q <= `GAIN_RESET;
		end else if (step_q == S_SMOOTH) begin
			gain_q <= gainNext;
		end
	end

	// ==========================================
	// Output sample, one-cycle strobe
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			devSample_q <= '{valid: 1'b0, left: `DEV_RESET, right: `DEV_RESET};
		end else if (step_q == S_OUT) begin
			devSample_q.valid <= 1'b1;
			devSample_q.left <= toDev(drcL, audioDeviation);
			devSample_q.right <= toDev(drcR, audioDeviation);
		end else begin
			devSample_q.valid <= 1'b0;
		end
	end

	assign devSample = devSample_q;
	assign quietFlag = quietFlag_q;
	assign loudFlag = loudFlag_q;

endmodule : tx_audio_level_conditioning

`default_nettype wire

// >>> verification/tx_audio_props.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port-level checks
module tx_audio_props
	import tx_audio_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire audio_pair_type lineSample, // Input sample
	input wire logic [15:0] audioDeviation, // Max deviation
	input wire dev_pair_type devSample, // Output sample
	input wire logic quietFlag, // Quiet indicator
	input wire logic loudFlag // Loud indicator
);
	logic [6:0] busyCnt_q; // Cycles since the taken sample
	logic signed [15:0] inL_q; // Taken left value
	logic signed [15:0] inR_q; // Taken right value
	logic devZero_q; // Taken with zero deviation
	wire logic takeNow = lineSample.valid && (busyCnt_q == 7'h00); // Sample accepted
	// Track one pass and what it started from
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busyCnt_q <= 7'h00;
			inL_q <= 16'sh0000;
			inR_q <= 16'sh0000;
			devZero_q <= 1'b0;
		end else if (takeNow) begin
			busyCnt_q <= 7'h01;
			inL_q <= lineSample.left;
			inR_q <= lineSample.right;
			devZero_q <= (audioDeviation == 16'h0000);
		end else if (busyCnt_q != 7'h00) begin
			busyCnt_q <= (busyCnt_q == 7'h3A) ? 7'h00 : busyCnt_q + 7'h01;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence sTake;
		takeNow;
	endsequence
	sequence sAnswer;
		##[56:58] devSample.valid;
	endsequence
	AST_LATENCY: assert property (sTake |-> sAnswer)
		else $error("Taken sample gave no output in time");
	AST_PULSE: assert property (devSample.valid |=> !devSample.valid)
		else $error("Output strobe longer than one cycle");
	AST_NO_SPURIOUS: assert property (devSample.valid |-> busyCnt_q inside {[55:58]})
		else $error("Output strobe without a taken sample");
	AST_HOLD: assert property (!devSample.valid |-> $stable({devSample.left, devSample.right}))
		else $error("Output data moved between samples");
	AST_QUIET_TIME: assert property ($changed(quietFlag) |-> busyCnt_q inside {[28:30]})
		else $error("Quiet flag moved outside sample update");
	AST_LOUD_TIME: assert property ($changed(loudFlag) |-> busyCnt_q inside {[28:30]})
		else $error("Loud flag moved outside sample update");
	AST_ZERO_IN: assert property (devSample.valid && inL_q == 16'sh0000 |-> devSample.left == 0)
		else $error("Silent input gave nonzero output");
	AST_SIGN: assert property (devSample.valid && inR_q[15] |-> !(devSample.right > 0))
		else $error("Negative input gave positive output");
	AST_STEREO: assert property (devSample.valid && inL_q == inR_q |-> devSample.left == devSample.right)
		else $error("Channels got different gain");
	AST_NO_DEV: assert property (devSample.valid && devZero_q |-> devSample.left == 0)
		else $error("Zero deviation gave nonzero output");
endmodule : tx_audio_props
bind tx_audio_level_conditioning tx_audio_props props (.clk(clk), .rst_n(rst_n),
	.lineSample(lineSample), .audioDeviation(audioDeviation), .devSample(devSample),
	.quietFlag(quietFlag), .loudFlag(loudFlag));
`default_nettype wire

// >>> verification/line_source.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Baseband source model
module line_source
	import tx_audio_pkg::*;
(
	input wire logic clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic sendReq, // Offer one sample
	input wire logic signed [15:0] sendLeft, // Left value
	input wire logic signed [15:0] sendRight, // Right value
	output var audio_pair_type lineSample // Sample toward the block
);
	// One-cycle strobe; data lines wander afterwards
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lineSample <= '0;
		end else if (sendReq) begin
			lineSample <= {1'b1, sendLeft, sendRight};
		end else begin
			lineSample.valid <= 1'b0;
			lineSample.left <= ~lineSample.left;
			lineSample.right <= ~lineSample.right;
		end
	end
endmodule : line_source
`default_nettype wire

// >>> verification/tx_audio_level_conditioning_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tx_audio_level_conditioning_tb_top
	import tx_audio_pkg::*;
;
	logic clk = 1'b0; // Bench clock
	logic rst_n, sendReq, quietFlag, loudFlag;
	logic signed [15:0] sendLeft, sendRight;
	audio_pair_type lineSample; // Source to block
	logic [1:0] lineAttenCode;
	logic [9:0] linePeakLevelMv;
	logic [15:0] audioDeviation, quietHoldTime, loudHoldTime;
	logic signed [7:0] quietThresholdDbfs, loudThresholdDbfs;
	drc_cfg_type drcCfg;
	dev_pair_type devSample;
	logic signed [16:0] gotL, gotR, a, b;
	int miscompares = 0;
	int checked = 0;
	line_source src (.clk(clk), .rst_n(rst_n), .sendReq(sendReq), .sendLeft(sendLeft),
		.sendRight(sendRight), .lineSample(lineSample));
	tx_audio_level_conditioning uut (.clk(clk), .rst_n(rst_n), .lineSample(lineSample),
		.lineAttenCode(lineAttenCode), .linePeakLevelMv(linePeakLevelMv),
		.audioDeviation(audioDeviation), .quietThresholdDbfs(quietThresholdDbfs),
		.loudThresholdDbfs(loudThresholdDbfs), .quietHoldTime(quietHoldTime),
		.loudHoldTime(loudHoldTime), .drcCfg(drcCfg), .devSample(devSample),
		.quietFlag(quietFlag), .loudFlag(loudFlag));
	always #2 clk = ~clk;
	task automatic conclude();
		$display("checked=%0d miscompares=%0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	task automatic chkV(input string what, input int e, input logic signed [16:0] g, input int t);
		checked++;
		if ($isunknown(g) || g < e - t || g > e + t) begin
			$display("[FAIL] %s expected %0d seen %0d", what, e, g);
			miscompares++;
		end
	endtask : chkV
	task automatic chkB(input string what, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %b seen %b", what, e, g);
			miscompares++;
		end
	endtask : chkB
	task automatic chkGt(input string what, input logic signed [16:0] hi, input logic signed [16:0] lo);
		checked++;
		if ($isunknown({hi, lo}) || !(hi > lo)) begin
			$display("[FAIL] %s expected above %0d seen %0d", what, lo, hi);
			miscompares++;
		end
	endtask : chkGt
	// Offer one sample, wait for its answer
	task automatic send(input logic signed [15:0] l, input logic signed [15:0] r);
		int n;
		n = 0;
		@(posedge clk);
		sendLeft <= l;
		sendRight <= r;
		sendReq <= 1'b1;
		@(posedge clk);
		sendReq <= 1'b0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (devSample.valid !== 1'b1 && n < 80);
		chkB("answer", 1'b1, devSample.valid);
		gotL = devSample.left;
		gotR = devSample.right;
		repeat (4) @(posedge clk);
	endtask : send
	task automatic prime(input logic signed [15:0] x, input int k);
		repeat (k) send(x, x);
	endtask : prime
	task automatic setDrc(input logic en, input logic [7:0] att, input logic [7:0] rel);
		drcCfg <= {en, 6'h0C, 8'hD8, att, rel};
	endtask : setDrc
	// Every range code at its own peak level
	task automatic testScale();
		logic [9:0] rng [4];
		rng = '{10'h0BE, 10'h12D, 10'h1A0, 10'h27C};
		for (int i = 0; i < 4; i++) begin
			lineAttenCode <= 2'(i);
			linePeakLevelMv <= rng[i];
			send(16'sh7FFF, 16'sh7FFF);
			chkV("full left", 6749, gotL, 2);
			chkV("full right", 6749, gotR, 2);
		end
		lineAttenCode <= 2'h2;
		linePeakLevelMv <= 10'h190;
		send(16'sh4000, -16'sh4000);
		chkV("half left", 3510, gotL, 2);
		chkV("half right", -3510, gotR, 2);
		lineAttenCode <= 2'h0;
		linePeakLevelMv <= 10'h0BE;
		audioDeviation <= 16'h03E8;
		send(16'sh7FFF, 16'sh7FFF);
		chkV("dev 1000", 999, gotL, 2);
		audioDeviation <= 16'h0000;
		send(16'sh4000, 16'sh4000);
		chkV("dev zero", 0, gotL, 0);
		audioDeviation <= 16'h1A5E;
	endtask : testScale
	// Quiet then loud indicators
	task automatic testFlags();
		prime(16'sh0000, 2);
		chkB("quiet early", 1'b0, quietFlag);
		send(16'sh0000, 16'sh0000);
		chkB("quiet set", 1'b1, quietFlag);
		send(16'sh7FFF, 16'sh7FFF);
		chkB("quiet clear", 1'b0, quietFlag);
		chkB("loud early", 1'b0, loudFlag);
		send(16'sh7FFF, 16'sh7FFF);
		chkB("loud set", 1'b1, loudFlag);
		send(16'sh0000, 16'sh0000);
		chkB("loud clear", 1'b0, loudFlag);
	endtask : testFlags
	// Compressor gain, bypass, attack and release
	task automatic testDrc();
		setDrc(1'b1, 8'hFF, 8'hFF);
		prime(16'sh0100, 3);
		chkV("quiet gain", 210, gotL, 8);
		setDrc(1'b0, 8'hFF, 8'hFF);
		send(16'sh0100, 16'sh0100);
		chkV("bypass", 52, gotL, 1);
		setDrc(1'b1, 8'h01, 8'hFF);
		prime(16'sh0100, 2);
		send(16'sh2000, 16'sh2000);
		a = gotL;
		setDrc(1'b1, 8'hFF, 8'hFF);
		prime(16'sh0100, 2);
		send(16'sh2000, 16'sh2000);
		chkV("compressed", 2546, gotL, 120);
		chkGt("slow attack", a, gotL);
		setDrc(1'b1, 8'hFF, 8'h01);
		prime(16'sh2000, 2);
		send(16'sh0100, 16'sh0100);
		b = gotL;
		setDrc(1'b1, 8'hFF, 8'hFF);
		prime(16'sh2000, 2);
		send(16'sh0100, 16'sh0100);
		chkGt("fast release", gotL, b);
	endtask : testDrc
	initial begin
		rst_n = 1'b0;
		sendReq = 1'b0;
		sendLeft = 16'sh0000;
		sendRight = 16'sh0000;
		lineAttenCode = 2'h0;
		linePeakLevelMv = 10'h0BE;
		audioDeviation = 16'h1A5E;
		quietThresholdDbfs = 8'shD8;
		loudThresholdDbfs = 8'shFA;
		quietHoldTime = 16'h0003;
		loudHoldTime = 16'h0002;
		drcCfg = '0;
		repeat (16) @(posedge clk);
		chkB("reset quiet", 1'b0, quietFlag);
		rst_n <= 1'b1;
		testScale();
		testFlags();
		testDrc();
		conclude();
	end
	initial begin
		#200000;
		miscompares++;
		conclude();
	end
endmodule : tx_audio_level_conditioning_tb_top
`default_nettype wire
